// [src/byte_eeprom_nvm_controller.sv]
// Byte EEPROM controller with APB register access and write sequencing
`timescale 1ns/10ps
module byte_eeprom_nvm_controller #(
  parameter int unsigned ERASE_CYCLES = nvm_ctrl_pkg::ERASE_CYC,
  parameter int unsigned PROG_CYCLES  = nvm_ctrl_pkg::PROG_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_external_pin_reset,
  input  wire logic        i_watchdog_timeout,
  input  wire logic        i_power_up_delay_window,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        i_table_write_instruction,
  input  wire logic [2:0]  i_table_pointer,
  input  wire logic [7:0]  i_table_latch,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_serial_access_en
);
  logic [1:0]  rst_sync_reg;
  wire         rst_n = rst_sync_reg[1];
  logic [7:0]  data_mem [nvm_ctrl_pkg::DATA_DEPTH];
  logic [7:0]  uid_mem  [nvm_ctrl_pkg::SECT_DEPTH];
  // Shipped as all zeros: no protection until a block program sets it
  logic [7:0]  cfg_mem  [nvm_ctrl_pkg::SECT_DEPTH] = '{default: 8'h00};
  logic [7:0]  hold_mem [nvm_ctrl_pkg::SECT_DEPTH];
  logic [21:0] target_location_reg;
  logic [15:0] memory_word_reg;
  logic        memctl_unlock_gate_reg;
  logic        memop_fault_flag_reg;
  logic        memop_done_irq_flag_reg;
  logic [1:0]  key_stage_reg;
  logic [1:0]  key_stage_next;
  logic [1:0]  prot_save_reg;
  logic [19:0] timer_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic        serial_en_reg;
  nvm_ctrl_pkg::state_t state_reg;
  nvm_ctrl_pkg::op_t    op_reg;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) rst_sync_reg <= 2'b00;
    else            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  // Bus decode; one wait state so every answer comes from a flop
  wire       apb_done  = i_psel & i_penable & pready_reg;
  wire       wr_en     = apb_done & i_pwrite;
  wire       sel_addr  = i_paddr == nvm_ctrl_pkg::OFF_ADDR;
  wire       sel_data  = i_paddr == nvm_ctrl_pkg::OFF_DATA;
  wire       sel_con0  = i_paddr == nvm_ctrl_pkg::OFF_CON0;
  wire       sel_cmd   = i_paddr == nvm_ctrl_pkg::OFF_CMD;
  wire       sel_key   = i_paddr == nvm_ctrl_pkg::OFF_KEY;
  wire       sel_stat  = i_paddr == nvm_ctrl_pkg::OFF_STATUS;
  wire       mapped    = sel_addr | sel_data | sel_con0 | sel_cmd | sel_key | sel_stat;
  wire [7:0] wd        = i_pwdata[7:0];
  wire       busy      = state_reg != nvm_ctrl_pkg::ST_IDLE;
  wire       soft_rst  = i_external_pin_reset | i_watchdog_timeout;

  // Space decode from the target address
  wire [21:0] ta       = target_location_reg;
  wire in_data  = ta[21:8] == nvm_ctrl_pkg::DATA_BASE[21:8];
  wire in_uid   = ta[21:3] == nvm_ctrl_pkg::UID_BASE[21:3];
  wire in_cfg   = ta[21:3] == nvm_ctrl_pkg::CFG_BASE[21:3];
  wire in_devid = ta[21:2] == nvm_ctrl_pkg::DEVID_BASE[21:2];
  wire wr_prot  = cfg_mem[0][1];
  wire code_prot = cfg_mem[0][0];

  // Key stage resets on any other write, so the request must follow directly
  wire unlocked = key_stage_reg == 2'd2;
  always_comb begin
    key_stage_next = key_stage_reg;
    if (wr_en) begin
      if (sel_key && wd == nvm_ctrl_pkg::KEY_FIRST)
        key_stage_next = 2'd1;
      else if (sel_key && wd == nvm_ctrl_pkg::KEY_SECOND && key_stage_reg == 2'd1)
        key_stage_next = 2'd2;
      else
        key_stage_next = 2'd0;
    end
  end

  // Requests: gate masks all, unlock needed for all but single read
  wire cmd_wr      = wr_en & sel_cmd & ~busy & memctl_unlock_gate_reg;
  wire fetch_req   = cmd_wr & wd[nvm_ctrl_pkg::FETCH_BIT];
  wire prog_req    = cmd_wr & unlocked & wd[nvm_ctrl_pkg::PROG_BIT];
  wire bprog_req   = cmd_wr & unlocked & wd[nvm_ctrl_pkg::BPROG_BIT];
  wire bwipe_req   = cmd_wr & unlocked & wd[nvm_ctrl_pkg::WIPE_BIT];
  wire bfetch_req  = cmd_wr & unlocked & wd[nvm_ctrl_pkg::BFETCH_BIT];
  wire data_ok     = in_data & ~wr_prot & ~i_power_up_delay_window;
  wire prog_ok     = prog_req & (data_ok | in_uid);
  wire bprog_ok    = bprog_req & in_cfg;
  wire bwipe_ok    = bwipe_req & in_uid;
  wire bfetch_ok   = bfetch_req & in_cfg;
  wire bad_req     = (prog_req & ~prog_ok) | (bprog_req & ~bprog_ok)
                   | (bwipe_req & ~bwipe_ok) | (bfetch_req & ~bfetch_ok);
  wire start_wr    = prog_ok | bprog_ok | bwipe_ok;
  wire abort_wr    = soft_rst & busy;
  wire erase_end   = state_reg == nvm_ctrl_pkg::ST_ERASE && timer_reg == 20'h00000;
  wire prog_end    = state_reg == nvm_ctrl_pkg::ST_PROG && timer_reg == 20'h00000;
  wire sw_fault_clr  = wr_en & sel_con0 & ~wd[nvm_ctrl_pkg::FAULT_BIT];
  wire sw_done_clr   = wr_en & sel_stat & ~wd[nvm_ctrl_pkg::DONE_BIT];
  wire set_done      = state_reg == nvm_ctrl_pkg::ST_DONE;

  wire [7:0] dev_byte  = 8'(nvm_ctrl_pkg::DEV_ID_VAL >> {ta[1:0], 3'b000});
  wire [7:0] read_byte = in_data  ? data_mem[ta[7:0]] :
                         in_uid   ? uid_mem[ta[2:0]]  :
                         in_cfg   ? cfg_mem[ta[2:0]]  :
                         in_devid ? dev_byte          : 8'h00;
  wire [7:0] cmd_view  = {1'b0,
                          busy && op_reg == nvm_ctrl_pkg::OP_WIPE,
                          busy && op_reg == nvm_ctrl_pkg::OP_CFG,
                          busy && op_reg == nvm_ctrl_pkg::OP_BYTE,
                          4'h0};
  wire [31:0] rd_mux   = sel_addr ? {10'h000, target_location_reg} :
                         sel_data ? {16'h0000, memory_word_reg} :
                         sel_con0 ? {24'h000000, memctl_unlock_gate_reg, 2'b00,
                                     memop_fault_flag_reg, 4'h0} :
                         sel_cmd  ? {24'h000000, cmd_view} :
                         sel_stat ? {30'h00000000, busy, memop_done_irq_flag_reg} :
                                    32'h00000000;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= i_psel & i_penable & ~pready_reg;
      pslverr_reg <= i_psel & i_penable & ~pready_reg & ~mapped;
      prdata_reg  <= rd_mux;
    end
  end

  // Gate: software only, cleared by any reset
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n)                   memctl_unlock_gate_reg <= 1'b0;
    else if (soft_rst)            memctl_unlock_gate_reg <= 1'b0;
    else if (wr_en && sel_con0)   memctl_unlock_gate_reg <= wd[nvm_ctrl_pkg::GATE_BIT];
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      memop_fault_flag_reg    <= 1'b0;
      memop_done_irq_flag_reg <= 1'b0;
    end else begin
      memop_fault_flag_reg    <= (bad_req | abort_wr)
                                 | (memop_fault_flag_reg & ~sw_fault_clr);
      memop_done_irq_flag_reg <= set_done | (memop_done_irq_flag_reg & ~sw_done_clr);
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_stage_reg       <= 2'd0;
      target_location_reg <= 22'h000000;
      memory_word_reg     <= 16'h0000;
      serial_en_reg       <= 1'b0;
    end else begin
      key_stage_reg <= soft_rst ? 2'd0 : key_stage_next;
      serial_en_reg <= ~code_prot;
      if (wr_en && sel_addr && !busy)
        target_location_reg <= i_pwdata[21:0];
      if (fetch_req)
        memory_word_reg <= {8'h00, read_byte};
      else if (wr_en && sel_data && !busy)
        memory_word_reg <= i_pwdata[15:0];
    end
  end

  // Write sequencer: erase phase then program phase, timer driven
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= nvm_ctrl_pkg::ST_IDLE;
      op_reg        <= nvm_ctrl_pkg::OP_BYTE;
      timer_reg     <= 20'h00000;
      prot_save_reg <= 2'b00;
    end else if (soft_rst) begin
      state_reg <= nvm_ctrl_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        nvm_ctrl_pkg::ST_IDLE: begin
          if (start_wr) begin
            state_reg     <= nvm_ctrl_pkg::ST_ERASE;
            timer_reg     <= 20'(ERASE_CYCLES - 1);
            prot_save_reg <= cfg_mem[0][1:0];
            op_reg        <= prog_ok  ? nvm_ctrl_pkg::OP_BYTE :
                             bprog_ok ? nvm_ctrl_pkg::OP_CFG  : nvm_ctrl_pkg::OP_WIPE;
          end
        end
        nvm_ctrl_pkg::ST_ERASE: begin
          if (erase_end) begin
            state_reg <= nvm_ctrl_pkg::ST_PROG;
            timer_reg <= 20'(PROG_CYCLES - 1);
          end else begin
            timer_reg <= timer_reg - 20'h00001;
          end
        end
        nvm_ctrl_pkg::ST_PROG: begin
          if (prog_end) state_reg <= nvm_ctrl_pkg::ST_DONE;
          else          timer_reg <= timer_reg - 20'h00001;
        end
        nvm_ctrl_pkg::ST_DONE: state_reg <= nvm_ctrl_pkg::ST_IDLE;
        default:               state_reg <= nvm_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // Array updates; arrays are nonvolatile so they carry no reset
  always_ff @(posedge i_ref_clk) begin
    if (erase_end && op_reg == nvm_ctrl_pkg::OP_BYTE) begin
      if (in_data) data_mem[ta[7:0]] <= nvm_ctrl_pkg::ERASED;
      else         uid_mem[ta[2:0]]  <= nvm_ctrl_pkg::ERASED;
    end
    if (prog_end && op_reg == nvm_ctrl_pkg::OP_BYTE) begin
      if (in_data) data_mem[ta[7:0]] <= memory_word_reg[7:0];
      else         uid_mem[ta[2:0]]  <= memory_word_reg[7:0];
    end
    for (int i = 0; i < nvm_ctrl_pkg::SECT_DEPTH; i++) begin
      if (erase_end && op_reg == nvm_ctrl_pkg::OP_WIPE)
        uid_mem[i] <= nvm_ctrl_pkg::ERASED;
      if (erase_end && op_reg == nvm_ctrl_pkg::OP_CFG)
        cfg_mem[i] <= nvm_ctrl_pkg::ERASED;
      if (prog_end && op_reg == nvm_ctrl_pkg::OP_CFG)
        cfg_mem[i] <= (i == 0) ? (hold_mem[i] | {6'h00, prot_save_reg}) : hold_mem[i];
      if (bfetch_ok)
        hold_mem[i] <= cfg_mem[i];
    end
    // Holding bytes loaded by table writes between block fetch and program
    if (i_table_write_instruction && !busy)
      hold_mem[i_table_pointer] <= i_table_latch;
  end

  assign o_prdata           = prdata_reg;
  assign o_pready           = pready_reg;
  assign o_pslverr          = pslverr_reg;
  assign o_serial_access_en = serial_en_reg;

  sequence s_write_start;
    state_reg == nvm_ctrl_pkg::ST_IDLE ##1 state_reg == nvm_ctrl_pkg::ST_ERASE;
  endsequence
  sequence s_erase_to_prog;
    state_reg == nvm_ctrl_pkg::ST_ERASE ##1 state_reg == nvm_ctrl_pkg::ST_PROG;
  endsequence

  gate_reset_clear_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    soft_rst |=> !memctl_unlock_gate_reg)
    else $error("Unlock gate survived a reset event");
  gate_hold_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    busy && !soft_rst && !(wr_en && sel_con0) |=> $stable(memctl_unlock_gate_reg))
    else $error("Unlock gate changed without software");
  locked_prog_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    wr_en && sel_cmd && !memctl_unlock_gate_reg && !busy |=> state_reg == nvm_ctrl_pkg::ST_IDLE)
    else $error("Write began with gate clear");
  unlock_needed_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    wr_en && sel_cmd && !unlocked && !busy |=> state_reg == nvm_ctrl_pkg::ST_IDLE)
    else $error("Write began without unlock");
  read_next_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    fetch_req |=> memory_word_reg == {8'h00, $past(read_byte)})
    else $error("Read byte not ready next cycle");
  addr_locked_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    busy |=> $stable(target_location_reg))
    else $error("Address changed during write");
  erase_first_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_write_start |-> timer_reg == 20'(ERASE_CYCLES - 1))
    else $error("Erase phase not timed from its start");
  prog_after_erase_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_erase_to_prog |-> $past(timer_reg, 1) == 20'h00000)
    else $error("Program phase entered early");
  done_flag_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    set_done |=> memop_done_irq_flag_reg && state_reg == nvm_ctrl_pkg::ST_IDLE)
    else $error("Completion not flagged");
  bad_fault_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    bad_req |=> memop_fault_flag_reg && state_reg == nvm_ctrl_pkg::ST_IDLE)
    else $error("Refused write not flagged");
  power_block_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    prog_req && in_data && i_power_up_delay_window |=> !busy)
    else $error("Data write during power-up window");
  abort_fault_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    abort_wr |=> memop_fault_flag_reg && !busy)
    else $error("Interrupted write not flagged");
  cfg_wipe_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    bwipe_req && in_cfg |=> !busy)
    else $error("Config block wipe performed");
  prot_keep_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    prog_end && op_reg == nvm_ctrl_pkg::OP_CFG
      |=> (cfg_mem[0][1:0] & prot_save_reg) == prot_save_reg)
    else $error("Protection bit was disabled");

  sequence s_key_second;
    wr_en && sel_key && wd == nvm_ctrl_pkg::KEY_SECOND && key_stage_reg == 2'd1 && !soft_rst;
  endsequence
  sequence s_cfg_wiped;
    cfg_mem[0] == nvm_ctrl_pkg::ERASED && cfg_mem[7] == nvm_ctrl_pkg::ERASED;
  endsequence

  gate_sw_only_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !soft_rst && !(wr_en && sel_con0) |=> $stable(memctl_unlock_gate_reg))
    else $error("Unlock gate changed by hardware");

  fetch_gated_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    wr_en && sel_cmd && !memctl_unlock_gate_reg |=> $stable(memory_word_reg))
    else $error("Read ran with gate clear");

  word_hold_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !fetch_req && !(wr_en && sel_data && !busy) |=> $stable(memory_word_reg))
    else $error("Data register lost its value");

  data_locked_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    busy |=> $stable(memory_word_reg))
    else $error("Data changed during write");

  gate_drop_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    busy && !soft_rst && wr_en && sel_con0 && !wd[nvm_ctrl_pkg::GATE_BIT]
      |=> busy || memop_done_irq_flag_reg)
    else $error("Write cut by gate clear");

  bus_runs_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    busy && i_psel && i_penable && !pready_reg |=> pready_reg)
    else $error("Bus stalled during write");

  prot_refuse_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    prog_req && in_data && wr_prot |=> memop_fault_flag_reg && !busy)
    else $error("Protected data write accepted");

  fault_sticky_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    memop_fault_flag_reg && !sw_fault_clr |=> memop_fault_flag_reg)
    else $error("Fault flag dropped by hardware");

  ser_follow_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    rst_n |=> serial_en_reg == !$past(code_prot))
    else $error("Serial access ignores code protect");

  devid_ro_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    prog_req && in_devid |=> memop_fault_flag_reg && !busy)
    else $error("Device ID write accepted");

  cfg_prog_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    prog_req && in_cfg |=> memop_fault_flag_reg && !busy)
    else $error("Config byte write accepted");

  array_block_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (bfetch_req || bprog_req) && in_data |=> memop_fault_flag_reg && !busy)
    else $error("Block access on data array");

  byte_prog_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    prog_end && op_reg == nvm_ctrl_pkg::OP_BYTE && in_data
      |=> data_mem[ta[7:0]] == memory_word_reg[7:0])
    else $error("Data byte not programmed");

  cfg_erase_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    erase_end && op_reg == nvm_ctrl_pkg::OP_CFG |=> s_cfg_wiped)
    else $error("Config sector not erased first");

  byte_erase_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    erase_end && op_reg == nvm_ctrl_pkg::OP_BYTE && in_data
      |=> data_mem[ta[7:0]] == nvm_ctrl_pkg::ERASED)
    else $error("Data byte not erased first");

  key_clear_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    wr_en && !sel_key |=> key_stage_reg == 2'd0)
    else $error("Key stage kept across a write");

  unlock_pair_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    s_key_second |=> unlocked)
    else $error("Key pair did not unlock");
endmodule // byte_eeprom_nvm_controller

// [src/nvm_ctrl_pkg.sv]
// Constants and types for the byte EEPROM nonvolatile memory controller
package nvm_ctrl_pkg;
  localparam logic [7:0]  OFF_ADDR   = 8'h00;
  localparam logic [7:0]  OFF_DATA   = 8'h04;
  localparam logic [7:0]  OFF_CON0   = 8'h08;
  localparam logic [7:0]  OFF_CMD    = 8'h0c;
  localparam logic [7:0]  OFF_KEY    = 8'h10;
  localparam logic [7:0]  OFF_STATUS = 8'h14;
  localparam int          GATE_BIT   = 7;
  localparam int          FAULT_BIT  = 4;
  localparam int          WIPE_BIT   = 6;
  localparam int          BPROG_BIT  = 5;
  localparam int          PROG_BIT   = 4;
  localparam int          BFETCH_BIT = 1;
  localparam int          FETCH_BIT  = 0;
  localparam int          DONE_BIT   = 0;
  localparam int          BUSY_BIT   = 1;
  localparam logic [7:0]  KEY_FIRST  = 8'h55;
  localparam logic [7:0]  KEY_SECOND = 8'haa;
  localparam logic [7:0]  ERASED     = 8'hff;
  localparam logic [21:0] DATA_BASE  = 22'h380000;
  localparam logic [21:0] UID_BASE   = 22'h200000;
  localparam logic [21:0] CFG_BASE   = 22'h300000;
  localparam logic [21:0] DEVID_BASE = 22'h3ffffc;
  localparam int          DATA_DEPTH = 256;
  localparam int          SECT_DEPTH = 8;
  localparam logic [31:0] DEV_ID_VAL = 32'h00a5_5a01;  // Arbitrary value
  localparam int          CLK_NS     = 50;
  localparam int          ERASE_NS   = 2000000;
  localparam int          PROG_NS    = 2000000;
  localparam int          ERASE_CYC  = (ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PROG_CYC   = (PROG_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG  = 2'b11,
    ST_DONE  = 2'b10
  } state_t;
  typedef enum logic [1:0] {
    OP_BYTE = 2'b00,
    OP_CFG  = 2'b01,
    OP_WIPE = 2'b10
  } op_t;
endpackage

// [tb/byte_eeprom_nvm_controller_tb.sv]
// Self-checking testbench for the byte EEPROM controller
`timescale 1ns/10ps
module byte_eeprom_nvm_controller_tb;
  localparam int          LIMIT    = 8000;
  localparam logic [21:0] BAD_ADDR [6] = '{22'h100000, 22'h3ffffc, 22'h300000,
                                           22'h300000, 22'h380000, 22'h380000};
  localparam logic [7:0]  BAD_CMD  [6] = '{8'h10, 8'h10, 8'h10, 8'h40, 8'h02, 8'h20};
  logic        ref_clk;
  logic        reset_n;
  logic        pin_rst;
  logic        wdt_rst;
  logic        pwr_win;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        tbl_wr;
  logic [2:0]  tbl_ptr;
  logic [7:0]  tbl_lat;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ser_en;
  logic [31:0] rdata;
  logic        rerr;
  int          errors;
  int          check_count;
  int          cycles;

  // Short counts keep each write to a few cycles
  byte_eeprom_nvm_controller #(.ERASE_CYCLES(4), .PROG_CYCLES(5)) dut (
    .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_external_pin_reset(pin_rst),
    .i_watchdog_timeout(wdt_rst), .i_power_up_delay_window(pwr_win), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_table_write_instruction(tbl_wr), .i_table_pointer(tbl_ptr),
    .i_table_latch(tbl_lat), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_serial_access_en(ser_en));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hung handshakes end here rather than spinning forever
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdata & m, e);
  endtask

  task automatic op(input logic [7:0] cmd);
    wr(nvm_ctrl_pkg::OFF_KEY, {24'h0, nvm_ctrl_pkg::KEY_FIRST});
    wr(nvm_ctrl_pkg::OFF_KEY, {24'h0, nvm_ctrl_pkg::KEY_SECOND});
    wr(nvm_ctrl_pkg::OFF_CMD, {24'h0, cmd});
  endtask

  // Busy is polled a bounded number of times, never assumed gone
  task automatic wait_idle;
    for (int n = 0; n < 40; n++) begin
      apb(1'b0, nvm_ctrl_pkg::OFF_STATUS, 32'h0);
      if (rdata[1] === 1'b0) break;
    end
    check({31'h0, rdata[1]}, 32'h0);
  endtask

  task automatic fetch(input logic [21:0] a, input logic [7:0] e);
    wr(nvm_ctrl_pkg::OFF_ADDR, {10'h0, a});
    wr(nvm_ctrl_pkg::OFF_CMD, 32'h01);
    rd_chk(nvm_ctrl_pkg::OFF_DATA, 32'hff, {24'h0, e});
  endtask

  task automatic fault_clr;
    rd_chk(nvm_ctrl_pkg::OFF_CON0, 32'h10, 32'h10);
    rd_chk(nvm_ctrl_pkg::OFF_STATUS, 32'h02, 32'h0);
    wr(nvm_ctrl_pkg::OFF_CON0, 32'h80);
  endtask

  task automatic hold(input logic [2:0] p, input logic [7:0] v);
    @(posedge ref_clk);
    tbl_wr  <= 1'b1;
    tbl_ptr <= p;
    tbl_lat <= v;
    @(posedge ref_clk);
    tbl_wr  <= 1'b0;
  endtask

  task automatic write_byte(input logic [21:0] a, input logic [7:0] v);
    wr(nvm_ctrl_pkg::OFF_ADDR, {10'h0, a});
    wr(nvm_ctrl_pkg::OFF_DATA, {24'h0, v});
    op(8'h10);
    wait_idle();
  endtask

  initial begin
    {reset_n, pin_rst, wdt_rst, pwr_win, psel, penable, pwrite, tbl_wr} = '0;
    {paddr, pwdata, tbl_ptr, tbl_lat, errors, check_count, cycles} = '0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_chk(nvm_ctrl_pkg::OFF_CON0, 32'h80, 32'h0);
    rd_chk(8'h18, 32'hffffffff, 32'h0);
    check({31'h0, rerr}, 32'h1);
    wr(nvm_ctrl_pkg::OFF_CON0, 32'h80);
    wr(nvm_ctrl_pkg::OFF_ADDR, 32'h380010);
    wr(nvm_ctrl_pkg::OFF_DATA, 32'h3c);
    op(8'h10);
    rd_chk(nvm_ctrl_pkg::OFF_CMD, 32'h10, 32'h10);
    wr(nvm_ctrl_pkg::OFF_ADDR, 32'h380020);
    wr(nvm_ctrl_pkg::OFF_CON0, 32'h00);
    wait_idle();
    rd_chk(nvm_ctrl_pkg::OFF_STATUS, 32'h01, 32'h01);
    rd_chk(nvm_ctrl_pkg::OFF_CMD, 32'hff, 32'h0);
    rd_chk(nvm_ctrl_pkg::OFF_ADDR, 32'h3fffff, 32'h380010);
    wr(nvm_ctrl_pkg::OFF_STATUS, 32'h0);
    rd_chk(nvm_ctrl_pkg::OFF_STATUS, 32'h01, 32'h0);
    wr(nvm_ctrl_pkg::OFF_DATA, 32'h11);
    wr(nvm_ctrl_pkg::OFF_CMD, 32'h01);
    rd_chk(nvm_ctrl_pkg::OFF_DATA, 32'hff, 32'h11);
    op(8'h10);
    rd_chk(nvm_ctrl_pkg::OFF_CMD, 32'hff, 32'h0);
    wr(nvm_ctrl_pkg::OFF_CON0, 32'h80);
    fetch(22'h380010, 8'h3c);
    wr(nvm_ctrl_pkg::OFF_DATA, 32'hff);
    wr(nvm_ctrl_pkg::OFF_CMD, 32'h10);
    rd_chk(nvm_ctrl_pkg::OFF_CMD, 32'hff, 32'h0);
    wr(nvm_ctrl_pkg::OFF_KEY, 32'h55);
    wr(nvm_ctrl_pkg::OFF_KEY, 32'haa);
    wr(nvm_ctrl_pkg::OFF_DATA, 32'hff);
    wr(nvm_ctrl_pkg::OFF_CMD, 32'h10);
    rd_chk(nvm_ctrl_pkg::OFF_CMD, 32'hff, 32'h0);
    fetch(22'h380010, 8'h3c);
    write_byte(22'h380010, nvm_ctrl_pkg::ERASED);
    fetch(22'h380010, 8'hff);
    rd_chk(nvm_ctrl_pkg::OFF_CON0, 32'h80, 32'h80);
    write_byte(22'h200003, 8'h5a);
    fetch(22'h200003, 8'h5a);
    fetch(22'h3ffffc, nvm_ctrl_pkg::DEV_ID_VAL[7:0]);
    wr(nvm_ctrl_pkg::OFF_ADDR, 32'h380010);
    pwr_win <= 1'b1;
    op(8'h10);
    fault_clr();
    pwr_win <= 1'b0;
    fetch(22'h380010, 8'hff);
    for (int i = 0; i < 6; i++) begin
      wr(nvm_ctrl_pkg::OFF_ADDR, {10'h0, BAD_ADDR[i]});
      op(BAD_CMD[i]);
      fault_clr();
    end
    for (int i = 0; i < 8; i++) hold(i[2:0], (i == 0) ? 8'h02 : 8'h10 + i[7:0]);
    wr(nvm_ctrl_pkg::OFF_ADDR, 32'h300000);
    op(8'h20);
    wait_idle();
    fetch(22'h300000, 8'h02);
    fetch(22'h300005, 8'h15);
    check({31'h0, ser_en}, 32'h1);
    wr(nvm_ctrl_pkg::OFF_ADDR, 32'h380040);
    op(8'h10);
    fault_clr();
    hold(3'h0, 8'h01);
    wr(nvm_ctrl_pkg::OFF_ADDR, 32'h300000);
    op(8'h20);
    wait_idle();
    fetch(22'h300000, 8'h03);
    check({31'h0, ser_en}, 32'h0);
    // Block fetch must overwrite the stale holding byte
    hold(3'h5, 8'h77);
    op(8'h02);
    op(8'h20);
    wait_idle();
    fetch(22'h300005, 8'h15);
    wr(nvm_ctrl_pkg::OFF_ADDR, 32'h200003);
    op(8'h40);
    wait_idle();
    fetch(22'h200003, 8'hff);
    // Pin reset, then watchdog, each cut into a running write
    for (int i = 0; i < 2; i++) begin
      wr(nvm_ctrl_pkg::OFF_CON0, 32'h80);
      wr(nvm_ctrl_pkg::OFF_ADDR, 32'h200001);
      op(8'h10);
      pin_rst <= (i == 0);
      wdt_rst <= (i == 1);
      @(posedge ref_clk);
      pin_rst <= 1'b0;
      wdt_rst <= 1'b0;
      rd_chk(nvm_ctrl_pkg::OFF_CON0, 32'h90, 32'h10);
      rd_chk(nvm_ctrl_pkg::OFF_STATUS, 32'h02, 32'h0);
    end
    complete_run();
  end
endmodule  // byte_eeprom_nvm_controller_tb
